// [srd_reset_gen.sv]
/*
 * srd_reset_gen: reset release delay generator for a supply detector.
 * Assumes the comparator indication and manual request come from outside the
 * clock domain, and that i_resetn is tied to the supply good indication.
 */
// Operation
// - With the active-low option, the reset output goes low while the supply is below threshold.
// - With the inverting option, the reset output goes high instead while the supply is below threshold.
// - After the supply recovers or manual reset is withdrawn, reset stays asserted for the release delay.
// - The manual reset request is active low and asserts reset while held low.
// - Brief supply dips are ignored; only a sustained low supply asserts reset.
// - The release delay option A, B or D selects 50, 100 or 200 ms as the terminal count.
// - The delay count is exact to the clock, well inside five percent of nominal.
`timescale 1ns/1ps
module srd_reset_gen #(
	parameter srd_pkg::srd_delay_t DELAY_SEL = srd_pkg::SRD_DLY_A,
	parameter bit INVERT_OUT = 1'b0,
	parameter int unsigned GLITCH_CYCLES = srd_pkg::GLITCH_CYC,
	parameter int unsigned DELAY_A_CYCLES = srd_pkg::DELAY_A_CYC,
	parameter int unsigned DELAY_B_CYCLES = srd_pkg::DELAY_B_CYC,
	parameter int unsigned DELAY_D_CYCLES = srd_pkg::DELAY_D_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire srd_pkg::srd_cause_t i_cause,
	output logic o_reset,
	output logic o_reset_active
);
	import srd_pkg::*;

	// ==========================================================================
	// input synchronisers
	// ==========================================================================
	srd_cause_t sync1_r;
	srd_cause_t sync2_r;

	// the first stage feeds only the second; power-up treats supply as low
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sync1_r <= '{below_threshold: 1'b1, manual_reset_request_n: 1'b1};
			sync2_r <= '{below_threshold: 1'b1, manual_reset_request_n: 1'b1};
		end else begin
			sync1_r <= i_cause;
			sync2_r <= sync1_r;
		end
	end

	// ==========================================================================
	// dip filter
	// ==========================================================================
	logic [FLT_W-1:0] flt_cnt_r;
	logic [FLT_W-1:0] flt_cnt_nxt;
	logic low_r;
	logic low_nxt;

	// a low supply must persist GLITCH_CYCLES before it counts; recovery is immediate
	always_comb begin
		flt_cnt_nxt = '0;
		low_nxt = low_r;
		if (!sync2_r.below_threshold) begin
			low_nxt = 1'b0;
		end else if (!low_r) begin
			if (flt_cnt_r >= FLT_W'(GLITCH_CYCLES - 1)) begin
				low_nxt = 1'b1;
			end else begin
				flt_cnt_nxt = flt_cnt_r + FLT_W'(1);
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			flt_cnt_r <= '0;
			low_r <= 1'b1;
		end else begin
			flt_cnt_r <= flt_cnt_nxt;
			low_r <= low_nxt;
		end
	end

	// ==========================================================================
	// release delay sequencer
	// ==========================================================================
	srd_state_t state_r;
	srd_state_t state_nxt;
	logic [CNT_W-1:0] dly_cnt_r;
	logic [CNT_W-1:0] dly_cnt_nxt;
	logic [CNT_W-1:0] term_cnt;
	logic cause;

	// terminal count fixed at build time by the option letter
	always_comb begin
		case (DELAY_SEL)
			SRD_DLY_B: term_cnt = CNT_W'(DELAY_B_CYCLES);
			SRD_DLY_D: term_cnt = CNT_W'(DELAY_D_CYCLES);
			default: term_cnt = CNT_W'(DELAY_A_CYCLES);
		endcase
	end

	assign cause = low_r | ~sync2_r.manual_reset_request_n;

	// any cause returns to hold, so the next release restarts the full count
	always_comb begin
		state_nxt = state_r;
		dly_cnt_nxt = dly_cnt_r;
		case (state_r)
			SRD_ST_HOLD: begin
				dly_cnt_nxt = '0;
				if (!cause) begin
					state_nxt = SRD_ST_COUNT;
				end
			end
			SRD_ST_COUNT: begin
				if (cause) begin
					state_nxt = SRD_ST_HOLD;
					dly_cnt_nxt = '0;
				end else if (dly_cnt_r >= term_cnt - CNT_W'(1)) begin
					state_nxt = SRD_ST_RUN;
				end else begin
					dly_cnt_nxt = dly_cnt_r + CNT_W'(1);
				end
			end
			SRD_ST_RUN: begin
				dly_cnt_nxt = '0;
				if (cause) begin
					state_nxt = SRD_ST_HOLD;
				end
			end
			default: begin
				state_nxt = SRD_ST_HOLD;
				dly_cnt_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_r <= SRD_ST_HOLD;
			dly_cnt_r <= '0;
		end else begin
			state_r <= state_nxt;
			dly_cnt_r <= dly_cnt_nxt;
		end
	end

	// ==========================================================================
	// output
	// ==========================================================================
	logic out_r;
	logic out_nxt;

	// registered so the pin never glitches during state changes
	always_comb begin
		if (INVERT_OUT) begin
			out_nxt = (state_nxt != SRD_ST_RUN);
		end else begin
			out_nxt = (state_nxt == SRD_ST_RUN);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			out_r <= INVERT_OUT;
		end else begin
			out_r <= out_nxt;
		end
	end

	assign o_reset = out_r;
	assign o_reset_active = (state_r != SRD_ST_RUN);

endmodule : srd_reset_gen

// [srd_pkg.sv]
/*
 * srd_pkg: constants and types for the supply reset delay generator.
 * Assumes a single core clock of 125 MHz; all timing counts derive from it.
 */
package srd_pkg;

	// ==========================================================================
	// timebase
	// ==========================================================================
	localparam int unsigned CLK_HZ = 125000000;
	localparam int unsigned CLK_PERIOD_NS = 8;

	// release delay options, in milliseconds
	localparam int unsigned DELAY_A_MS = 50;
	localparam int unsigned DELAY_B_MS = 100;
	localparam int unsigned DELAY_D_MS = 200;

	// cycle counts for each option (exact: 125000 cycles per ms)
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned DELAY_A_CYC = DELAY_A_MS * CYC_PER_MS;
	localparam int unsigned DELAY_B_CYC = DELAY_B_MS * CYC_PER_MS;
	localparam int unsigned DELAY_D_CYC = DELAY_D_MS * CYC_PER_MS;

	// least time a dip must persist to count as sustained, in ns
	localparam int unsigned GLITCH_NS = 10000;
	localparam int unsigned GLITCH_CYC_RAW = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned GLITCH_CYC = (GLITCH_CYC_RAW < 1) ? 1 : GLITCH_CYC_RAW;

	localparam int CNT_W = 25;
	localparam int FLT_W = 11;

	// ==========================================================================
	// types
	// ==========================================================================
	typedef enum logic [1:0] {
		SRD_DLY_A = 2'h0,
		SRD_DLY_B = 2'h1,
		SRD_DLY_D = 2'h2
	} srd_delay_t;

	typedef enum logic [2:0] {
		SRD_ST_HOLD = 3'h1,
		SRD_ST_COUNT = 3'h2,
		SRD_ST_RUN = 3'h4
	} srd_state_t;

	// raw reset causes, carried together
	typedef struct packed {
		logic below_threshold;
		logic manual_reset_request_n;
	} srd_cause_t;

	// delay option to terminal count
	function automatic logic [CNT_W-1:0] srd_delay_cycles(input srd_delay_t sel);
		logic [CNT_W-1:0] c;
		c = CNT_W'(DELAY_A_CYC);
		case (sel)
			SRD_DLY_B: c = CNT_W'(DELAY_B_CYC);
			SRD_DLY_D: c = CNT_W'(DELAY_D_CYC);
			default: c = CNT_W'(DELAY_A_CYC);
		endcase
		return c;
	endfunction : srd_delay_cycles

endpackage : srd_pkg

// [srd_reset_gen_checker.sv]
/* port checker for srd_reset_gen.
   assumes one core clock and bind to every instance */
`timescale 1ns/1ps
module srd_reset_gen_checker #(parameter bit INVERT_OUT = 1'b0, parameter int DLY = 20) (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire srd_pkg::srd_cause_t i_cause,
	input wire logic o_reset,
	input wire logic o_reset_active
);
	import srd_pkg::*;
	int clr_r;
	logic ok;
	// ==========
	// cycles since both causes cleared; glitches restart it, so only release moments use it
	assign ok = i_cause.manual_reset_request_n && !i_cause.below_threshold;
	always_ff @(posedge i_core_clk or negedge i_resetn)
		if (!i_resetn) clr_r <= 0; else clr_r <= ok ? clr_r + 1 : 0;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	AST_POL: assert property (o_reset == (INVERT_OUT ? o_reset_active : !o_reset_active))
		else $error("reset polarity wrong");
	AST_RST: assert property (disable iff (1'b0) !i_resetn |-> o_reset_active)
		else $error("reset not held in power-on");
	AST_MAN: assert property ($fell(i_cause.manual_reset_request_n) |-> ##[1:4] o_reset_active)
		else $error("manual request not seen");
	AST_MHOLD: assert property (!i_cause.manual_reset_request_n [*4] |=> o_reset_active)
		else $error("reset dropped during manual request");
	AST_EARLY: assert property ($fell(o_reset_active) |-> clr_r >= DLY)
		else $error("release too early");
	AST_LATE: assert property (clr_r == DLY + 8 |-> !o_reset_active)
		else $error("release too late");
	AST_GL: assert property (i_cause.below_threshold [*8] |-> ##[0:3] o_reset_active)
		else $error("sustained low supply ignored");
	AST_STAY: assert property (ok [*4] ##0 !o_reset_active |=> !o_reset_active)
		else $error("reset without cause");
	cover property ($fell(o_reset_active));
	cover property ($rose(o_reset_active) && i_cause.manual_reset_request_n);
	cover property ($fell(i_cause.manual_reset_request_n) && o_reset_active);
endmodule : srd_reset_gen_checker
bind srd_reset_gen srd_reset_gen_checker #(.INVERT_OUT(INVERT_OUT),
	.DLY(DELAY_SEL == 1 ? DELAY_B_CYCLES : DELAY_SEL == 2 ? DELAY_D_CYCLES : DELAY_A_CYCLES)) u_chk (
	.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_cause(i_cause), .o_reset(o_reset),
	.o_reset_active(o_reset_active));

// [srd_sys_model.sv]
/* system logic that pulls the manual reset request.
   assumes the core clock; changes only at the falling edge */
`timescale 1ns/1ps
module srd_sys_model (
	input wire logic i_core_clk,
	output logic o_manual_reset_request_n
);
	initial o_manual_reset_request_n = 1'b1;
	// active low request held for n cycles
	task automatic press(input int n);
		@(negedge i_core_clk) o_manual_reset_request_n = 1'b0;
		repeat (n) @(negedge i_core_clk);
		o_manual_reset_request_n = 1'b1;
	endtask : press
endmodule : srd_sys_model

// [srd_reset_gen_tb.sv]
/* testbench: options A, B inverted and D side by side.
   assumes shortened counts: filter 4, delays 20/40/80 */
`timescale 1ns/1ps
module srd_reset_gen_tb;
	import srd_pkg::*;
	// shortened counts so the run stays short
	localparam int unsigned SIM_GLITCH = 4;
	localparam int unsigned SIM_DLY_A = 20;
	localparam int unsigned SIM_DLY_B = 40;
	localparam int unsigned SIM_DLY_D = 80;
	logic i_core_clk = 1'b0, i_resetn = 1'b0, below = 1'b0, man_n;
	logic [2:0] rst, act;
	int n_fail = 0, n_checks = 0, dly[3] = '{SIM_DLY_A, SIM_DLY_B, SIM_DLY_D};
	srd_cause_t cause;
	assign cause = '{below_threshold: below, manual_reset_request_n: man_n};
	srd_sys_model pm (.i_core_clk(i_core_clk), .o_manual_reset_request_n(man_n));
	for (genvar g = 0; g < 3; g++) begin : g_dut
		srd_reset_gen #(.DELAY_SEL(srd_delay_t'(g)), .INVERT_OUT(g == 1), .GLITCH_CYCLES(SIM_GLITCH),
			.DELAY_A_CYCLES(SIM_DLY_A), .DELAY_B_CYCLES(SIM_DLY_B), .DELAY_D_CYCLES(SIM_DLY_D))
			uut (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
			.i_cause(cause), .o_reset(rst[g]), .o_reset_active(act[g]));
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (exp !== got) begin
			n_fail++;
			$display("ERROR %s expected %0d seen %0d", what, exp, got);
		end
	endtask : chk
	// cycles until each variant releases, judged against its own option
	task automatic rel(input string what);
		int t[3] = '{0, 0, 0};
		for (int c = 1; c < 120; c++) begin
			@(negedge i_core_clk);
			for (int g = 0; g < 3; g++) if (act[g] !== 1'b0) t[g] = c;
		end
		for (int g = 0; g < 3; g++) chk(what, 1, t[g] >= dly[g] && t[g] <= dly[g] + 8);
		chk("released level", 3'b101, rst);
		$display("test %s done", what);
	endtask : rel
	task automatic t_manual;
		pm.press(12);
		chk("manual level", 3'b010, rst);
		rel("manual");
	endtask : t_manual
	task automatic t_supply;
		logic seen = 1'b0;
		@(negedge i_core_clk) below = 1'b1;
		repeat (2) @(negedge i_core_clk);
		below = 1'b0;
		repeat (12) @(negedge i_core_clk) seen |= |act;
		chk("dip ignored", 0, seen);
		below = 1'b1;
		repeat (12) @(negedge i_core_clk);
		chk("supply low level", 3'b010, rst);
		below = 1'b0;
		rel("supply");
	endtask : t_supply
	task automatic t_restart;
		pm.press(5);
		repeat (10) @(negedge i_core_clk);
		pm.press(3);
		rel("restart");
	endtask : t_restart
	task automatic end_sim;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_sim
	initial forever #4 i_core_clk = ~i_core_clk;
	initial begin
		repeat (3) @(negedge i_core_clk);
		i_resetn = 1'b1;
		rel("power up");
		t_manual();
		t_supply();
		t_restart();
		end_sim();
	end
	// about 540 cycles expected; cut a hang well after
	initial begin
		#20000;
		n_fail++;
		end_sim();
	end
endmodule : srd_reset_gen_tb
